/* rtl/flh_host.sv */
// Host-side bus controller driving a byte-wide sector-erase flash
`timescale 1ns/1ps
`default_nettype none
// Function
// - Read: select and gate low, strobe high
// - Write: strobe and select low, gate high
// - Wait full access time after selecting
// - Elevated bit 9, bit 6 low selects codes
// - Protect check: sector address, answer 1/0
// - Reset command leaves identification mode
module flh_host
  import flh_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  input  wire logic              i_clk_en,
  // Command port
  input  wire logic              i_req,
  input  wire logic [1:0]        i_op,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  output logic                   o_busy,
  output logic                   o_done,
  output logic [DATA_W-1:0]      o_rdata,
  // Flash pins
  output logic                   o_ce_n,
  output logic                   o_oe_n,
  output logic                   o_we_n,
  output logic [ADDR_W-1:0]      o_addr,
  output logic                   o_id_hv,
  input  wire logic [DATA_W-1:0] i_dq,
  output logic [DATA_W-1:0]      o_dq,
  output logic                   o_dq_oe
);

  flh_tmr_if tmr_if ();

  flh_timer u_timer (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_clk_en (i_clk_en),
    .tmr      (tmr_if.tmr)
  );

  // ==========================================================
  // Data pin synchroniser
  logic [DATA_W-1:0] dq_meta_reg;
  logic [DATA_W-1:0] dq_sync_reg;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      dq_meta_reg <= '0;
      dq_sync_reg <= '0;
    end else if (i_clk_en) begin
      dq_meta_reg <= i_dq;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  // ==========================================================
  // Bus sequencer
  flh_state_t        state_reg,  state_next;
  logic              ce_n_reg,   ce_n_next;
  logic              oe_n_reg,   oe_n_next;
  logic              we_n_reg,   we_n_next;
  logic              hv_reg,     hv_next;
  logic              dq_oe_reg,  dq_oe_next;
  logic              busy_reg,   busy_next;
  logic              done_reg,   done_next;
  logic [ADDR_W-1:0] addr_reg,   addr_next;
  logic [DATA_W-1:0] dq_reg,     dq_next;
  logic [DATA_W-1:0] rdata_reg,  rdata_next;
  flh_op_t           op;

  assign op = flh_op_t'(i_op);

  always_comb begin
    state_next    = state_reg;
    ce_n_next     = ce_n_reg;
    oe_n_next     = oe_n_reg;
    we_n_next     = we_n_reg;
    hv_next       = hv_reg;
    dq_oe_next    = dq_oe_reg;
    busy_next     = busy_reg;
    done_next     = 1'b0;
    addr_next     = addr_reg;
    dq_next       = dq_reg;
    rdata_next    = rdata_reg;
    tmr_if.start  = 1'b0;
    tmr_if.cycles = RD_WAIT_CYC;
    case (state_reg)
      ST_IDLE: begin
        if (i_req) begin
          busy_next = 1'b1;
          // Sector index rides on top address bits
          addr_next = i_addr;
          ce_n_next = 1'b0;
          if (op == FLH_OP_READ || op == FLH_OP_ID_HV) begin
            oe_n_next    = 1'b0;
            tmr_if.start = 1'b1;
            state_next   = ST_READ;
            if (op == FLH_OP_ID_HV) begin
              // Elevated bit 9 with bit 6 low
              hv_next               = 1'b1;
              // Sector bits kept for protect check
              addr_next[ID_LOW_BIT] = 1'b0;
            end
          end else begin
            // Address set up with gate high first
            oe_n_next  = 1'b1;
            dq_next    = (op == FLH_OP_RESET) ? RESET_CMD_BYTE : i_wdata;
            state_next = ST_WE_LOW;
          end
        end
      end
      ST_READ: begin
        // Sample only after access time and sync
        if (tmr_if.done) begin
          rdata_next = dq_sync_reg;
          ce_n_next  = 1'b1;
          oe_n_next  = 1'b1;
          hv_next    = 1'b0;
          done_next  = 1'b1;
          state_next = ST_RECOVER;
        end
      end
      ST_WE_LOW: begin
        // Strobe falls after address is stable
        if (we_n_reg) begin
          we_n_next     = 1'b0;
          dq_oe_next    = 1'b1;
          tmr_if.start  = 1'b1;
          tmr_if.cycles = WE_LOW_CYC;
        end else if (tmr_if.done) begin
          // Data held past the strobe rise
          we_n_next     = 1'b1;
          tmr_if.start  = 1'b1;
          tmr_if.cycles = WE_HOLD_CYC;
          state_next    = ST_WE_HIGH;
        end
      end
      ST_WE_HIGH: begin
        if (tmr_if.done) begin
          ce_n_next  = 1'b1;
          dq_oe_next = 1'b0;
          done_next  = 1'b1;
          state_next = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // One cycle of standby keeps drivers from overlapping
        busy_next  = 1'b0;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      // Pins idle deselected; device sits in array-read
      state_reg <= ST_IDLE;
      ce_n_reg  <= 1'b1;
      oe_n_reg  <= 1'b1;
      we_n_reg  <= 1'b1;
      hv_reg    <= 1'b0;
      dq_oe_reg <= 1'b0;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
      addr_reg  <= '0;
      dq_reg    <= '0;
      rdata_reg <= '0;
    end else if (i_clk_en) begin
      state_reg <= state_next;
      ce_n_reg  <= ce_n_next;
      oe_n_reg  <= oe_n_next;
      we_n_reg  <= we_n_next;
      hv_reg    <= hv_next;
      dq_oe_reg <= dq_oe_next;
      busy_reg  <= busy_next;
      done_reg  <= done_next;
      addr_reg  <= addr_next;
      dq_reg    <= dq_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_ce_n  = ce_n_reg;
  assign o_oe_n  = oe_n_reg;
  assign o_we_n  = we_n_reg;
  assign o_id_hv = hv_reg;
  assign o_dq_oe = dq_oe_reg;
  assign o_busy  = busy_reg;
  assign o_done  = done_reg;
  assign o_addr  = addr_reg;
  assign o_dq    = dq_reg;
  assign o_rdata = rdata_reg;

  // ==========================================================
  // Checks
  logic [TMR_W-1:0] sel_cnt_reg;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || o_ce_n) begin
      sel_cnt_reg <= '0;
    end else if (i_clk_en && sel_cnt_reg != '1) begin
      sel_cnt_reg <= sel_cnt_reg + TMR_W'(1);
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  no_contention_a : assert property (o_dq_oe |-> o_oe_n)
    else $error("Host drives data while gate is low");
  write_levels_a : assert property (!o_we_n |-> o_oe_n && !o_ce_n)
    else $error("Write strobe low without select or with gate low");
  read_levels_a : assert property (!o_oe_n |-> !o_ce_n && o_we_n)
    else $error("Gate low without select or with strobe low");
  read_wait_a : assert property (
    state_reg == ST_READ && tmr_if.done |-> sel_cnt_reg >= RD_WAIT_CYC)
    else $error("Read data sampled before access time");
  addr_hold_a : assert property (!o_we_n |-> $stable(o_addr))
    else $error("Address moved while strobe low");
  data_hold_a : assert property (
    $rose(o_we_n) |-> o_dq_oe && $stable(o_dq) ##1 o_dq_oe)
    else $error("Data not held across strobe rise");
  id_levels_a : assert property (o_id_hv |-> !o_addr[ID_LOW_BIT] && !o_ce_n)
    else $error("Elevated id with bit 6 high or deselected");
  idle_standby_a : assert property (
    state_reg == ST_IDLE |-> o_ce_n && !o_dq_oe && o_oe_n && o_we_n)
    else $error("Bus not in standby while idle");
  write_start_a : assert property (
    i_clk_en && state_reg == ST_IDLE && i_req && op == FLH_OP_WRITE
    |=> !o_ce_n && o_we_n ##1 !o_we_n)
    else $error("Write strobe not one cycle after select");

  // Done is registered, so the first three covers look at the timer pulse in-state
  read_cov_c  : cover property (state_reg == ST_READ && tmr_if.done);
  write_cov_c : cover property (state_reg == ST_WE_HIGH && tmr_if.done);
  id_cov_c    : cover property (o_id_hv && tmr_if.done);
  reset_cmd_c : cover property (!o_we_n && o_dq == RESET_CMD_BYTE);

endmodule : flh_host
`default_nettype wire

/* rtl/flh_pkg.sv */
// Shared constants and types for the flash bus host controller
package flh_pkg;

  // ==========================================================
  // Clock and pin timing
  localparam int CLK_PERIOD_NS = 20;
  // Worst-case chip-select access time of the slowest speed grade
  localparam int T_ACC_NS      = 150;
  // Write strobe low width and data hold after its rise
  localparam int T_WE_LOW_NS   = 50;
  localparam int T_WE_HOLD_NS  = 20;
  localparam int SYNC_STAGES   = 2;

  localparam int ACC_CYC  = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WLO_CYC  = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WHO_CYC  = (T_WE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int TMR_W = 8;
  // Read sample waits for access time plus the input synchroniser
  localparam logic [TMR_W-1:0] RD_WAIT_CYC = TMR_W'(ACC_CYC + SYNC_STAGES + 1);
  localparam logic [TMR_W-1:0] WE_LOW_CYC  = TMR_W'(WLO_CYC);
  localparam logic [TMR_W-1:0] WE_HOLD_CYC = TMR_W'(WHO_CYC);

  // ==========================================================
  // Address and data layout
  localparam int ADDR_W      = 19;
  localparam int DATA_W      = 8;
  localparam int SECT_MSB    = 18;
  localparam int SECT_LSB    = 16;
  localparam int ID_LOW_BIT  = 6;
  // Reset command byte, plain default
  localparam logic [DATA_W-1:0] RESET_CMD_BYTE = 8'hF0;

  // ==========================================================
  // Host operations and controller states
  typedef enum logic [1:0] {
    FLH_OP_READ,
    FLH_OP_WRITE,
    FLH_OP_ID_HV,
    FLH_OP_RESET
  } flh_op_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WE_LOW,
    ST_WE_HIGH,
    ST_RECOVER
  } flh_state_t;

endpackage : flh_pkg

/* rtl/flh_tmr_if.sv */
// Interface between the controller and its interval timer
`timescale 1ns/1ps
`default_nettype none
interface flh_tmr_if;
  import flh_pkg::*;
  logic             start;
  logic [TMR_W-1:0] cycles;
  logic             done;

  modport ctrl (output start, output cycles, input done);
  modport tmr  (input start, input cycles, output done);
endinterface : flh_tmr_if
`default_nettype wire

/* rtl/flh_timer.sv */
// Interval timer: done pulses a set number of cycles after start
`timescale 1ns/1ps
`default_nettype none
module flh_timer
  import flh_pkg::*;
(
  // Clock and control
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_clk_en,
  // Timer channel
  flh_tmr_if.tmr    tmr
);

  logic [TMR_W-1:0] cnt_reg;
  logic [TMR_W-1:0] cnt_next;
  logic             done_reg;
  logic             done_next;

  // ==========================================================
  // Count down
  always_comb begin
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    if (tmr.start) begin
      cnt_next = tmr.cycles;
    end else if (cnt_reg != '0) begin
      cnt_next  = cnt_reg - TMR_W'(1);
      done_next = (cnt_reg == TMR_W'(1));
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else if (i_clk_en) begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign tmr.done = done_reg;

endmodule : flh_timer
`default_nettype wire

/* verification/flh_flash_model.sv */
// Behavioural byte-wide flash as seen from its pins
`timescale 1ns/1ps
`default_nettype none
module flh_flash_model
  import flh_pkg::*;
#(
  parameter logic [7:0] MAKER  = 8'h3C, // Arbitrary code
  parameter logic [7:0] PART   = 8'h5A, // Arbitrary code
  parameter logic [7:0] PROT   = 8'h08,
  parameter logic [7:0] ID_CMD = 8'h90,
  parameter logic [7:0] STATUS    = 8'h4C,
  parameter logic [7:0] ERASE_CMD = 8'h30,
  parameter int         ERASE_NS  = 680
)(
  // Flash pins
  input  wire logic              i_ce_n,
  input  wire logic              i_oe_n,
  input  wire logic              i_we_n,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_id_hv,
  input  wire logic [DATA_W-1:0] i_dq,
  output logic      [DATA_W-1:0] o_dq
);
  logic [DATA_W-1:0] rd_val;
  logic              id_mode = 1'b0;
  logic              erasing = 1'b0;
  logic              valid   = 1'b0;
  wire               drv     = !i_ce_n && !i_oe_n && i_we_n;
  wire               wr_on   = !i_ce_n && !i_we_n && i_oe_n;

  always @(negedge wr_on) begin
    id_mode = (i_dq == ID_CMD);
    // Sector erase runs on even while deselected
    if (i_dq == ERASE_CMD) begin
      erasing = 1'b1;
      erasing <= #(ERASE_NS) 1'b0;
    end
  end

  always_comb begin
    rd_val = i_addr[7:0] ^ {5'h00, i_addr[SECT_MSB:SECT_LSB]};
    // Status replaces array data while erasing
    if (erasing) begin
      rd_val = STATUS;
    end else if (i_id_hv && i_addr[ID_LOW_BIT]) begin
      rd_val = 8'hFF;
    end else if (i_id_hv || id_mode) begin
      case (i_addr[1:0])
        2'h0:    rd_val = MAKER;
        2'h1:    rd_val = PART;
        2'h2:    rd_val = {7'h00, PROT[i_addr[SECT_MSB:SECT_LSB]]};
        default: rd_val = 8'h00;
      endcase
    end
  end

  // Garbage until access time has run
  always @(drv) begin
    valid = 1'b0;
    if (drv) #(T_ACC_NS) valid = drv;
  end

  // No pull on the bus, released lines show inverse
  assign o_dq = valid ? rd_val : ~rd_val;
endmodule : flh_flash_model
`default_nettype wire

/* verification/tb_flash_bus_operation_decode.sv */
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module tb_flash_bus_operation_decode;
  import flh_pkg::*;
  typedef struct {logic [1:0] op; logic [ADDR_W-1:0] a; logic [7:0] wd; logic [7:0] exp;} flh_row_t;
  localparam logic [7:0] MAKER  = 8'h3C; // Arbitrary code
  localparam logic [7:0] PART   = 8'h5A; // Arbitrary code
  localparam logic [7:0] ID_CMD = 8'h90;
  localparam logic [7:0] STATUS    = 8'h4C;
  localparam logic [7:0] ERASE_CMD = 8'h30;

  logic              i_clock = 1'b0;
  logic              i_rst_n = 1'b0;
  logic              i_clk_en = 1'b1;
  logic              i_req = 1'b0;
  logic [1:0]        i_op = 2'h0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [7:0]        i_wdata = 8'h00;
  logic              o_busy, o_done, o_ce_n, o_oe_n, o_we_n, o_id_hv, o_dq_oe;
  logic [7:0]        o_rdata, o_dq, flash_dq, dq_in, rd;
  logic [ADDR_W-1:0] o_addr;
  int                mismatches = 0;
  int                n_tests = 0;
  int                cycles = 0;
  int                bad, cyc;
  flh_row_t          rows [18];

  assign dq_in = o_dq_oe ? o_dq : flash_dq;
  always #10 i_clock = ~i_clock;

  flh_host dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_req(i_req),
    .i_op(i_op), .i_addr(i_addr), .i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done),
    .o_rdata(o_rdata), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_addr(o_addr),
    .o_id_hv(o_id_hv), .i_dq(dq_in), .o_dq(o_dq), .o_dq_oe(o_dq_oe));
  // Erase lasts past two status reads but ends before the freeze read
  flh_flash_model #(.MAKER(MAKER), .PART(PART), .PROT(8'h08), .ID_CMD(ID_CMD),
    .STATUS(STATUS), .ERASE_CMD(ERASE_CMD), .ERASE_NS(680)) u_flash (
    .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_addr(o_addr), .i_id_hv(o_id_hv),
    .i_dq(dq_in), .o_dq(flash_dq));

  function automatic logic [7:0] mem(input logic [ADDR_W-1:0] a);
    return a[7:0] ^ {5'h00, a[SECT_MSB:SECT_LSB]};
  endfunction : mem

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chkn(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkn

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // One request; counts edges from the taking edge to done
  task automatic run(input logic [1:0] op, input logic [ADDR_W-1:0] a, input logic [7:0] wd);
    @(posedge i_clock);
    i_req   <= 1'b1;
    i_op    <= op;
    i_addr  <= a;
    i_wdata <= wd;
    @(posedge i_clock);
    i_req <= 1'b0;
    cyc = 0;
    bad = 0;
    do begin
      @(posedge i_clock);
      #1;
      cyc++;
      if (!o_we_n && (o_oe_n !== 1'b1 || o_ce_n !== 1'b0)) bad++;
      if (!o_oe_n && (o_we_n !== 1'b1 || o_dq_oe !== 1'b0)) bad++;
      if (o_busy !== 1'b1) bad++;
      if (o_id_hv && (o_oe_n !== 1'b0 || o_addr[ID_LOW_BIT] !== 1'b0)) bad++;
    end while (o_done !== 1'b1 && cyc < 40);
    rd = o_rdata;
    @(posedge i_clock);
  endtask : run

  // Ceiling well above about 300 cycles of tests
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    rows[0]  = '{FLH_OP_READ,  19'h1_2345, 8'h00, mem(19'h1_2345)};
    rows[1]  = '{FLH_OP_READ,  19'h7_FFFF, 8'h00, mem(19'h7_FFFF)};
    rows[2]  = '{FLH_OP_ID_HV, 19'h0_0000, 8'h00, MAKER};
    rows[3]  = '{FLH_OP_ID_HV, 19'h6_0041, 8'h00, PART};
    rows[4]  = '{FLH_OP_ID_HV, 19'h3_0002, 8'h00, 8'h01};
    rows[5]  = '{FLH_OP_ID_HV, 19'h4_0002, 8'h00, 8'h00};
    rows[6]  = '{FLH_OP_WRITE, 19'h0_0555, ID_CMD, 8'h00};
    rows[7]  = '{FLH_OP_READ,  19'h5_0001, 8'h00, PART};
    rows[8]  = '{FLH_OP_READ,  19'h3_0012, 8'h00, 8'h01};
    rows[9]  = '{FLH_OP_RESET, 19'h0_0000, 8'h00, 8'h00};
    rows[10] = '{FLH_OP_READ,  19'h5_0001, 8'h00, mem(19'h5_0001)};
    rows[11] = '{FLH_OP_WRITE, 19'h0_0555, ID_CMD, 8'h00};
    rows[12] = '{FLH_OP_READ,  19'h0_0100, 8'h00, MAKER};
    rows[13] = '{FLH_OP_WRITE, 19'h0_0000, 8'h33, 8'h00};
    rows[14] = '{FLH_OP_READ,  19'h0_0102, 8'h00, mem(19'h0_0102)};
    rows[15] = '{FLH_OP_WRITE, 19'h2_0000, ERASE_CMD, 8'h00};
    rows[16] = '{FLH_OP_READ,  19'h2_0005, 8'h00, STATUS};
    rows[17] = '{FLH_OP_READ,  19'h7_0003, 8'h00, STATUS};
    repeat (10) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    #1;
    chk8({3'h0, o_ce_n, o_oe_n, o_we_n, o_dq_oe, o_busy}, 8'h1C);
    // Table rows; a write ends one edge after its hold interval
    for (int i = 0; i < 18; i++) begin
      run(rows[i].op, rows[i].a, rows[i].wd);
      if (!rows[i].op[0]) chk8(rd, rows[i].exp);
      chkn(cyc, rows[i].op[0] ? 3 + int'(WE_LOW_CYC) + int'(WE_HOLD_CYC) : int'(RD_WAIT_CYC) + 1);
      chkn(bad, 0);
      $display("test %0d done", i);
    end
    // Frozen clock enable stretches a read by four edges
    fork
      run(FLH_OP_READ, 19'h2_0777, 8'h00);
      begin
        repeat (3) @(posedge i_clock);
        i_clk_en <= 1'b0;
        repeat (4) @(posedge i_clock);
        i_clk_en <= 1'b1;
      end
    join
    chkn(cyc, int'(RD_WAIT_CYC) + 5);
    chk8(rd, mem(19'h2_0777));
    $display("test freeze done");
    // Reset in mid-write
    @(posedge i_clock);
    i_req   <= 1'b1;
    i_op    <= FLH_OP_WRITE;
    i_wdata <= 8'h33;
    @(posedge i_clock);
    i_req <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    #1;
    chk8({3'h0, o_ce_n, o_oe_n, o_we_n, o_dq_oe, o_busy}, 8'h1C);
    run(FLH_OP_READ, 19'h6_00A5, 8'h00);
    chk8(rd, mem(19'h6_00A5));
    $display("test reset done");
    end_of_test();
  end
endmodule : tb_flash_bus_operation_decode
`default_nettype wire
